// file: inc/t1lcd_defs.svh
/*
  Constants of the T1 loop-code detector: register indices, field
  positions, reset values, codes and the persistence time.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef T1LCD_DEFS_SVH
`define T1LCD_DEFS_SVH

// Clock rate and persistence time
`define LCD_CLK_HZ        32'd100000000
`define LCD_PERSIST_S     32'd5

// Register indices; byte address is four times the index
`define LCD_CTRL_IDX      16'h0F03
`define LCD_MASK_IDX      16'h0F04
`define LCD_STAT_IDX      16'h0F05
`define LCD_ADDR(i)       ({14'h0000, (i), 2'h0})

// Control register fields
`define LCD_SEL_HI        7
`define LCD_SEL_LO        6
`define LCD_CODE_BIT      5
`define LCD_CTRL_RST      8'h00

// Status and mask field
`define LCD_FLAG_BIT      3
`define LCD_LOOP_BIT      0
`define LCD_MASK_RST      1'b0

// Detection select codes
`define LCD_SEL_OFF       2'h0
`define LCD_SEL_UP        2'h1
`define LCD_SEL_DOWN      2'h2
`define LCD_SEL_AUTO      2'h3

// Pattern window lengths and shift register reset
`define LCD_UP_LEN        5
`define LCD_DOWN_LEN      3
`define LCD_SHIFT_INIT    5'h1F

// Bus constants
`define LCD_HTRANS_ACT    1
`define LCD_HRESP_OKAY    1'b0
`define LCD_ZERO32        32'h0000_0000

`endif

// file: inc/t1lcd_pkg.sv
/*
  Types of the T1 loop-code detector: bus request carrier, receive
  line carrier and the automatic-mode states.
  Assumes t1lcd_defs.svh is reachable on the include path.
*/
`include "t1lcd_defs.svh"

package t1lcd_pkg;

  // AHB-Lite request signals from the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } t1lcd_ahb_req_t;

  // Received line bit stream
  typedef struct packed {
    logic bit_valid;
    logic bit_val;
    logic single_rail;
  } t1lcd_line_rx_t;

  // Automatic loop-back sequencing
  typedef enum logic [1:0] {
    LCD_AUTO_OFF,
    LCD_AUTO_WAIT_UP,
    LCD_AUTO_LOOPED
  } t1lcd_auto_t;

endpackage

// file: rtl/t1lcd_top.sv
/*
  One channel of the T1 network loop-code detector with its AHB-Lite
  register slave, sticky status, mask and level interrupt.
  Assumes one 100 MHz clock, receive bits qualified by a strobe that is
  synchronous to it, and word-sized single AHB-Lite transfers.
  Persistence is counted in clock cycles; the default count gives 5 s
  at 100 MHz, and a bench may shrink it to keep runs short.
*/
`timescale 1ns/1ns
`include "t1lcd_defs.svh"

module t1lcd_top
#(
  parameter logic [31:0] PERSIST_CYCLES = `LCD_PERSIST_S * `LCD_CLK_HZ
)
(
  input  wire logic                      clock,
  input  wire logic                      nrst,
  input  wire t1lcd_pkg::t1lcd_ahb_req_t ahb_req,
  input  wire t1lcd_pkg::t1lcd_line_rx_t line_rx,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic                           irq,
  output logic                           remote_loopback,
  output logic                           line_code_ami,
  output logic                           loop_code_seen_flag
);
  import t1lcd_pkg::*;

  // Exactly one set bit in a window
  // Shared by both windows; zero padding keeps one helper for the short one
  function automatic logic lcd_onehot(input logic [4:0] v);
    logic [4:0] m;
    m = v & (v - 5'h01);
    return (v != 5'h00) && (m == 5'h00);
  endfunction

  // Registers
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        mask_q;
  logic        flag_q;
  logic        flag_d;
  logic        remote_q;
  logic        remote_d;
  t1lcd_auto_t state_q;
  t1lcd_auto_t state_d;
  logic [4:0]  shift_q;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [1:0]  pat_q;
  logic        irq_q;
  logic        ami_q;
  logic [31:0] hrdata_q;
  logic        hready_q;
  logic        hresp_q;
  logic        rd_pend_q;
  logic [2:0]  rd_sel_q;
  logic        wr_ctrl_q;
  logic        wr_mask_q;
  logic        wr_stat_q;

  // Bus decode
  wire logic        addr_take;
  wire logic        hit_ctrl;
  wire logic        hit_mask;
  wire logic        hit_stat;
  wire logic        take_rd;
  wire logic        take_wr;
  wire logic [31:0] rd_mux;
  wire logic [7:0]  stat_byte;
  wire logic [7:0]  mask_byte;

  // Pattern logic
  wire logic [1:0]  sel;
  wire logic [1:0]  pat_d;
  wire logic        up_ok;
  wire logic        down_ok;
  wire logic        match;
  wire logic        same_pat;
  wire logic        detect;
  wire logic        enter_auto;
  wire logic        w1c_flag;
  wire logic        terminate;

  // Address phase qualification and address compare
  // Qualified by the bus ready, so a stalled address phase
  // is never taken twice
  assign addr_take = ahb_req.hsel & ahb_req.htrans[`LCD_HTRANS_ACT]
                     & ahb_req.hready;
  assign hit_ctrl  = ahb_req.haddr == `LCD_ADDR(`LCD_CTRL_IDX);
  assign hit_mask  = ahb_req.haddr == `LCD_ADDR(`LCD_MASK_IDX);
  assign hit_stat  = ahb_req.haddr == `LCD_ADDR(`LCD_STAT_IDX);
  assign take_rd   = addr_take & ~ahb_req.hwrite;
  assign take_wr   = addr_take & ahb_req.hwrite;

  // Read data assembly; unmapped addresses read zero
  // Selects are one-hot, registered at the address phase
  assign stat_byte = {4'h0, flag_q, 2'h0, remote_q};
  assign mask_byte = {4'h0, mask_q, 3'h0};
  assign rd_mux    = rd_sel_q[0] ? {24'h000000, ctrl_q} :
                     rd_sel_q[1] ? {24'h000000, mask_byte} :
                     rd_sel_q[2] ? {24'h000000, stat_byte} :
                     `LCD_ZERO32;

  // Bus handshake: reads take one wait state, writes none
  // The wait state lets the read mux settle from registered selects,
  // so a read right behind a write sees the freshly written value
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hready_q  <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_sel_q  <= 3'h0;
      wr_ctrl_q <= 1'b0;
      wr_mask_q <= 1'b0;
      wr_stat_q <= 1'b0;
    end
    else
    begin
      hready_q  <= ~take_rd;
      rd_pend_q <= take_rd;
      rd_sel_q  <= take_rd ? {hit_stat, hit_mask, hit_ctrl} : 3'h0;
      wr_ctrl_q <= take_wr & hit_ctrl;
      wr_mask_q <= take_wr & hit_mask;
      wr_stat_q <= take_wr & hit_stat;
    end
  end

  // Read data captured in the wait state; it then stands until
  // the next read completes
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hrdata_q <= `LCD_ZERO32;
    else if (rd_pend_q)
      hrdata_q <= rd_mux;
  end

  // Response is always OKAY; kept in a flop so the port is registered
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hresp_q <= `LCD_HRESP_OKAY;
    else
      hresp_q <= `LCD_HRESP_OKAY;
  end

  // Mask register; only the flag enable bit is stored,
  // the other bits read back as zero
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      mask_q <= `LCD_MASK_RST;
    else if (wr_mask_q)
      mask_q <= ahb_req.hwdata[`LCD_FLAG_BIT];
  end

  // Control register; hardware end of auto mode wins over software
  // Unused low bits are kept so software reads back what it wrote
  assign sel       = ctrl_q[`LCD_SEL_HI:`LCD_SEL_LO];
  assign terminate = (state_q == LCD_AUTO_LOOPED) & detect;

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl_q)
      ctrl_d = ahb_req.hwdata[7:0];
    if (terminate)
      ctrl_d[`LCD_SEL_HI:`LCD_SEL_LO] = `LCD_SEL_OFF;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ctrl_q <= `LCD_CTRL_RST;
    else
      ctrl_q <= ctrl_d;
  end

  // Receive bit history; newest bit in the low position
  // Bits without the strobe are ignored, so the idle level between
  // strobes never disturbs the window; a fill of ones matches nothing
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      shift_q <= `LCD_SHIFT_INIT;
    else if (line_rx.bit_valid)
      shift_q <= {shift_q[3:0], line_rx.bit_val};
  end

  // Pattern windows: one 1 in five bits, or one 1 in three bits
  // Every phase of a repeating code gives the same count of ones,
  // so no alignment to the code boundary is needed
  assign up_ok   = lcd_onehot(shift_q[`LCD_UP_LEN-1:0]);
  assign down_ok = lcd_onehot({2'h0,
                               shift_q[`LCD_DOWN_LEN-1:0]});

  // Pattern under watch, from select field and auto state
  // Auto state overrides the select field, so a rewrite of the select
  // while looped cannot leave loop-back without loop-down
  assign pat_d =
    (state_q == LCD_AUTO_LOOPED)  ? `LCD_SEL_DOWN :
    (state_q == LCD_AUTO_WAIT_UP) ? `LCD_SEL_UP :
    (sel == `LCD_SEL_UP)          ? `LCD_SEL_UP :
    (sel == `LCD_SEL_DOWN)        ? `LCD_SEL_DOWN :
    `LCD_SEL_OFF;

  assign match = (pat_q == `LCD_SEL_UP)   ? up_ok :
                 (pat_q == `LCD_SEL_DOWN) ? down_ok :
                 1'b0;
  assign same_pat = pat_d == pat_q;

  // Persistence over the threshold marks a detection, once
  // Equality fires for one cycle only; the counter then sits above
  // the threshold until the run breaks
  assign detect = match
                  & same_pat
                  & (cnt_q == PERSIST_CYCLES - 32'd1);

  // Persistence counter, saturating, restarted on mismatch
  // A change of watched pattern restarts it too, so a run begun under
  // the old pattern never counts toward the new one
  always_comb
  begin
    if (!match || !same_pat)
      cnt_d = `LCD_ZERO32;
    else if (cnt_q < PERSIST_CYCLES)
      cnt_d = cnt_q + 32'd1;
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= `LCD_ZERO32;
      pat_q <= `LCD_SEL_OFF;
    end
    else
    begin
      cnt_q <= cnt_d;
      pat_q <= pat_d;
    end
  end

  // Automatic loop-back sequencing
  // Once looped only a loop-down detection leaves; the select field
  // is not consulted there, so software cannot drop the loop-back
  assign enter_auto = (state_q == LCD_AUTO_OFF)
                      & (sel == `LCD_SEL_AUTO);

  always_comb
  begin
    state_d  = state_q;
    remote_d = remote_q;
    case (state_q)
      LCD_AUTO_OFF:
      begin
        if (sel == `LCD_SEL_AUTO)
          state_d = LCD_AUTO_WAIT_UP;
      end
      LCD_AUTO_WAIT_UP:
      begin
        if (sel != `LCD_SEL_AUTO)
          state_d = LCD_AUTO_OFF;
        else if (detect)
        begin
          state_d  = LCD_AUTO_LOOPED;
          remote_d = 1'b1;
        end
      end
      LCD_AUTO_LOOPED:
      begin
        if (detect)
        begin
          state_d  = LCD_AUTO_OFF;
          remote_d = 1'b0;
        end
      end
      default:
      begin
        state_d  = LCD_AUTO_OFF;
        remote_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q  <= LCD_AUTO_OFF;
      remote_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      remote_q <= remote_d;
    end
  end

  // Sticky flag: detection wins over both clears
  // An event in the same cycle as a clear must not be lost
  assign w1c_flag = wr_stat_q & ahb_req.hwdata[`LCD_FLAG_BIT];

  always_comb
  begin
    if (detect)
      flag_d = 1'b1;
    else if (w1c_flag || enter_auto)
      flag_d = 1'b0;
    else
      flag_d = flag_q;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // Interrupt level and line-code selection outputs
  // Interrupt follows the masked flag one cycle late, being registered;
  // the line-code choice is gated by single rail, since in dual rail
  // the coding is settled outside this block
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_q <= 1'b0;
      ami_q <= 1'b0;
    end
    else
    begin
      irq_q <= flag_q & mask_q;
      ami_q <= line_rx.single_rail
               & ctrl_q[`LCD_CODE_BIT];
    end
  end

  // Port drive
  assign hrdata              = hrdata_q;
  assign hreadyout           = hready_q;
  assign hresp               = hresp_q;
  assign irq                 = irq_q;
  assign remote_loopback     = remote_q;
  assign line_code_ami       = ami_q;
  assign loop_code_seen_flag = flag_q;

endmodule

// file: tb/t1lcd_properties.sv
/*
  Port checker of the T1 loop-code detector, bound to the top module.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/1ns
module t1lcd_properties
#(
  parameter logic [31:0] PERSIST_CYCLES = 32'd50
)
(
  input wire logic                      clock,
  input wire logic                      nrst,
  input wire t1lcd_pkg::t1lcd_ahb_req_t ahb_req,
  input wire t1lcd_pkg::t1lcd_line_rx_t line_rx,
  input wire logic [31:0]               hrdata,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire logic                      irq,
  input wire logic                      remote_loopback,
  input wire logic                      line_code_ami,
  input wire logic                      loop_code_seen_flag
);
  import t1lcd_pkg::*;
  logic [4:0]  win_q;
  logic [31:0] up_q;
  logic [31:0] dn_q;
  wire up_ok = $countones(win_q) == 1;
  wire dn_ok = $countones(win_q[2:0]) == 1;
  wire take  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  // Own bit window and run lengths of matched cycles
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      win_q <= 5'h1F;
      up_q  <= '0;
      dn_q  <= '0;
    end
    else
    begin
      if (line_rx.bit_valid)
        win_q <= {win_q[3:0], line_rx.bit_val};
      up_q <= up_ok ? up_q + 32'h1 : '0;
      dn_q <= dn_ok ? dn_q + 32'h1 : '0;
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_read_wait: assert property (
    take && !ahb_req.hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_fast: assert property (take && ahb_req.hwrite |=> hreadyout)
    else $error("write stalled");
  a_flag_persist: assert property (
    $rose(loop_code_seen_flag) |->
      up_q >= PERSIST_CYCLES || dn_q >= PERSIST_CYCLES)
    else $error("flag set too early");
  a_irq_cause: assert property (
    irq |-> $past(loop_code_seen_flag))
    else $error("interrupt without flag");
  a_ami_rail: assert property (
    line_code_ami |-> $past(line_rx.single_rail))
    else $error("line code acts outside single rail");
  a_loop_up: assert property (
    $rose(remote_loopback) |-> up_q >= PERSIST_CYCLES ##[0:1]
      loop_code_seen_flag)
    else $error("loop-back entered wrongly");
  a_loop_release: assert property (
    $fell(remote_loopback) |-> dn_q >= PERSIST_CYCLES)
    else $error("loop-back released early");
  a_loop_hold: assert property (
    remote_loopback && !dn_ok |=> remote_loopback)
    else $error("loop-back dropped without loop-down");

  c_loop_on: cover property ($rose(remote_loopback));
  c_loop_off: cover property ($fell(remote_loopback));
  c_irq: cover property ($rose(irq));
endmodule

bind t1lcd_top t1lcd_properties #(.PERSIST_CYCLES(PERSIST_CYCLES))
  u_t1lcd_properties (.clock(clock), .nrst(nrst), .ahb_req(ahb_req),
  .line_rx(line_rx), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .irq(irq), .remote_loopback(remote_loopback),
  .line_code_ami(line_code_ami),
  .loop_code_seen_flag(loop_code_seen_flag));

// file: tb/t1lcd_far_end.sv
/*
  Far-end terminal model: repeating loop-up, loop-down or idle ones.
  Assumes the bench chooses the pattern and the pace.
*/
`timescale 1ns/1ns
module t1lcd_far_end
(
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic [1:0]           mode,
  input  wire logic                 slow,
  input  wire logic                 rail,
  output t1lcd_pkg::t1lcd_line_rx_t line_rx
);
  import t1lcd_pkg::*;
  logic [2:0] pos_q;
  wire  [2:0] last = (mode == 2'h1) ? 3'h4 : 3'h2;
  wire        go   = !slow || !line_rx.bit_valid;

  // One bit a cycle, or every other one; idle data is inverted
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
    begin
      pos_q   <= 3'h0;
      line_rx <= '0;
    end
    else
    begin
      line_rx.bit_valid   <= go;
      line_rx.bit_val     <= go ? (mode == 2'h0 || pos_q == last)
                                : ~line_rx.bit_val;
      line_rx.single_rail <= rail;
      if (go)
        pos_q <= (pos_q >= last) ? 3'h0 : pos_q + 3'h1;
    end
endmodule

// file: tb/test_t1lcd_top.sv
/*
  Bench of the loop-code detector: bus tasks, far-end model, checks.
  Assumes the port checker is bound to the detector.
*/
`timescale 1ns/1ns
`include "t1lcd_defs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_t1lcd_top;
  import t1lcd_pkg::*;
  localparam logic [31:0] N = 32'd50;
  logic           clock = 1'b0;
  logic           nrst = 1'b0;
  t1lcd_ahb_req_t req = '0;
  t1lcd_line_rx_t rx;
  logic [31:0]    hrdata, rd, w;
  logic           hreadyout, hresp, irq, loopb, ami, flag, m, e;
  logic [1:0]     mode = 2'h0;
  logic           slow = 1'b0;
  logic           rail = 1'b0;
  int             failures = 0;
  int             compares = 0;
  int             cycles = 0;

  t1lcd_top #(.PERSIST_CYCLES(N)) u_t1lcd_top (.clock(clock), .nrst(nrst),
    .ahb_req(req), .line_rx(rx), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .remote_loopback(loopb),
    .line_code_ami(ami), .loop_code_seen_flag(flag));
  t1lcd_far_end u_t1lcd_far_end (.clock(clock), .nrst(nrst), .mode(mode),
    .slow(slow), .rail(rail), .line_rx(rx));

  // Clock, single-slave ready and hang limit
  always #5 clock = ~clock;
  always @* req.hready = hreadyout;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end

  task automatic results();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One single word transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [15:0] i,
                      input logic [31:0] wd);
    req.hsel   <= 1'b1;
    req.htrans <= 2'h2;
    req.hsize  <= 3'h2;
    req.hwrite <= wr;
    req.haddr  <= `LCD_ADDR(i);
    do @(posedge clock); while (hreadyout !== 1'b1);
    req.hsel   <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Far end sends a pattern long enough to count as persistent
  task automatic run(input logic [1:0] p);
    mode <= p;
    slow <= 1'($urandom);
    repeat (N + 40) @(posedge clock);
  endtask

  function automatic logic hit(input logic [1:0] s, input logic [1:0] p);
    return s != 2'h0 && s == p;
  endfunction

  initial
  begin
    void'($urandom(92927));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    // Reset values, then an unmapped place
    xfer(1'b1, 16'h0F06, $urandom);
    for (int k = 3; k < 7; k++)
    begin
      xfer(1'b0, 16'h0F00 + 16'(k), 32'h0);
      `CHK({hresp, rd}, 33'h0)
    end
    // Line code choice and read-back
    rail <= 1'b1;
    w = 32'h20 | ($urandom & 32'h1F);
    xfer(1'b1, `LCD_CTRL_IDX, w);
    xfer(1'b0, `LCD_CTRL_IDX, 32'h0);
    `CHK(rd, w)
    repeat (3) @(posedge clock);
    `CHK(ami, 1'b1)
    rail <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(ami, 1'b0)
    rail <= 1'b1;
    // Select codes off, loop-up and loop-down against both patterns, mask drawn at random
    for (int s = 0; s < 3; s++)
      for (int p = 1; p < 3; p++)
      begin
        m = 1'($urandom);
        e = hit(2'(s), 2'(p));
        xfer(1'b1, `LCD_MASK_IDX, {28'h0, m, 3'h0});
        xfer(1'b1, `LCD_CTRL_IDX, {24'h0, 2'(s), 6'h0});
        xfer(1'b1, `LCD_STAT_IDX, 32'h8);
        xfer(1'b0, `LCD_MASK_IDX, 32'h0);
        `CHK(rd, {28'h0, m, 3'h0})
        run(2'(p));
        `CHK(flag, e)
        `CHK(irq, e & m)
        `CHK(ami, 1'b0)
        run(2'h0);
      end
    // Automatic mode: entry, loop-down ignored, loop-up, hold
    xfer(1'b1, `LCD_CTRL_IDX, 32'hC0);
    repeat (3) @(posedge clock);
    `CHK(flag, 1'b0)
    run(2'h2);
    `CHK(loopb, 1'b0)
    run(2'h1);
    `CHK(loopb, 1'b1)
    xfer(1'b0, `LCD_STAT_IDX, 32'h0);
    `CHK(rd, 32'h9)
    run(2'h0);
    // Software picks loop-up only while looped; hardware must clear it
    xfer(1'b1, `LCD_CTRL_IDX, 32'h40);
    run(2'h0);
    `CHK({loopb, flag}, 2'h3)
    run(2'h2);
    `CHK(loopb, 1'b0)
    xfer(1'b0, `LCD_CTRL_IDX, 32'h0);
    `CHK(rd[7:6], 2'h0)
    xfer(1'b1, `LCD_STAT_IDX, 32'h8);
    xfer(1'b0, `LCD_STAT_IDX, 32'h0);
    `CHK(rd, 32'h0)
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    results();
  end
endmodule
